// ### src/floppy_port_regs.svh
/*
 Field positions, limits and reset values of the floppy interface register port.
 Assumes: vector index = 11 - printed bit number (printed bit 0 is the MSB).
*/
`ifndef FLOPPY_PORT_REGS_SVH
`define FLOPPY_PORT_REGS_SVH

// Interface register width
`define FP_WORD_W 12

// Command word fields
`define FP_MAINT_BIT 7
`define FP_WIDE8_BIT 6
`define FP_UNIT_BIT 4
`define FP_FUNC_MSB 3
`define FP_FUNC_LSB 1
`define FP_DENS_BIT 8
`define FP_CMD2_DENS_BIT 0
`define FP_IE_BIT 0

// Status word fields
`define FP_ST_CRC 0
`define FP_ST_INIT 2
`define FP_ST_DUAL 3
`define FP_ST_DEN_ERR 4
`define FP_ST_UNIT_DEN 5
`define FP_ST_ERASED 6
`define FP_ST_READY 7

// Address fields: low byte used, upper nibble ignored
`define FP_ADDR_MSB 7
`define FP_TRACK_LAST 76
`define FP_SECTOR_FIRST 1
`define FP_SECTOR_LAST 26

// Skip flag indices
`define FP_FLAG_TR 0
`define FP_FLAG_ERR 1
`define FP_FLAG_DONE 2

// Reset values
`define FP_WIDE8_RST 1'b0
`define FP_FLAG_RST 1'b0

`endif

// ### src/floppy_port_pkg.sv
/*
 Types shared by the floppy interface register port.
 Assumes: the _regs header is on the include path.
*/
`include "floppy_port_regs.svh"

package floppy_port_pkg;

    // Host I/O operations, in instruction code order
    typedef enum logic [2:0] {op_nop, command_load_op, data_move_op, request_skip_op,
                              error_skip_op, done_skip_op, irq_enable_op, init_op} io_op_t;

    // Function codes, in code order 000..111
    typedef enum logic [2:0] {fn_fill, fn_empty, fn_write, fn_read,
                              fn_density, fn_status, fn_write_del, fn_fault} func_t;

    // Protocol step: picks the logical register
    typedef enum logic [2:0] {st_idle, st_cmd2, st_sector, st_track,
                              st_data_in, st_data_out, st_busy} step_t;

    typedef struct packed {
        logic flag;
    } flag_state_t;

    typedef struct packed {
        logic maint;
        logic irq_en;
        logic wide8;
        func_t func;
        logic unit;
        logic dens;
        step_t step;
        logic [`FP_WORD_W-1:0] iface;
        logic [`FP_WORD_W-1:0] ac_word;
        logic ac_load;
        logic skip;
        logic go;
        logic init;
    } port_state_t;

endpackage

// ### src/sticky_flag.sv
/*
 One skip flag: set by hardware, cleared by a skip or initialize.
 Assumes: set, clear and force come from logic on clock_in.
*/
`timescale 1ns/1ns
`default_nettype none

module sticky_flag
    import floppy_port_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic clear_in,
    input wire logic force_in,
    output logic flag_out
);

    flag_state_t state_q;
    flag_state_t state_d;

    // Set and force win over clear
    always_comb
    begin
        state_d = state_q;
        state_d.flag = set_in | force_in | (state_q.flag & ~clear_in);
    end

    // State register
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            state_q <= '{flag: `FP_FLAG_RST};
        else
            state_q <= state_d;
    end

    assign flag_out = state_q.flag;

    // ************
    // Checks
    // ************
    AST_SET_WINS: assert property (@(posedge clock_in) disable iff (rst_in)
        set_in |=> flag_out) else $error("flag lost its set");
    AST_FORCE_HOLDS: assert property (@(posedge clock_in) disable iff (rst_in)
        force_in && clear_in |=> flag_out) else $error("forced flag was cleared");

endmodule
`default_nettype wire

// ### src/floppy_interface_register_port.sv
/*
 Host-side interface of a twin-drive floppy subsystem: one 12-bit interface
 register, command decode, maintenance loopback, skip flags, interrupt.
 Assumes: host I/O strobes and controller events are on clock_in.
*/
`timescale 1ns/1ns
`default_nettype none
`include "floppy_port_regs.svh"

module floppy_interface_register_port
    import floppy_port_pkg::*;
#(
    parameter bit DUAL_DENSITY = 1'b1,
    parameter int TRACK_LAST = `FP_TRACK_LAST,
    parameter int SECTOR_LAST = `FP_SECTOR_LAST
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic io_strobe_in,
    input wire io_op_t io_op_in,
    input wire logic [`FP_WORD_W-1:0] host_main_reg_in,
    output logic [`FP_WORD_W-1:0] host_main_reg_out,
    output logic host_main_reg_load_out,
    output logic host_skip_out,
    output logic host_irq_out,
    output logic word_request_flag_out,
    output logic error_flag_out,
    output logic done_flag_out,
    input wire logic ctrl_request_in,
    input wire logic ctrl_done_in,
    input wire logic ctrl_error_in,
    input wire logic [`FP_WORD_W-1:0] ctrl_word_in,
    input wire logic ctrl_crc_err_in,
    input wire logic ctrl_init_done_in,
    input wire logic ctrl_density_err_in,
    input wire logic [1:0] ctrl_unit_density_in,
    input wire logic ctrl_erased_mark_in,
    input wire logic ctrl_unit_ready_in,
    output logic [`FP_WORD_W-1:0] ctrl_iface_out,
    output logic ctrl_go_out,
    output logic ctrl_init_out,
    output func_t ctrl_func_out,
    output logic ctrl_unit_out,
    output logic ctrl_dens_out,
    output logic ctrl_wide8_out
);

    // ************
    // Parameter check
    // ************
    generate
        if (TRACK_LAST < 0 || TRACK_LAST > 255 || SECTOR_LAST < 1 || SECTOR_LAST > 255)
        begin : g_bad_limits
            $error("address limits must fit in one byte");
        end
    endgenerate

    port_state_t state_q;
    port_state_t state_d;
    logic [2:0] flag_q;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [`FP_WORD_W-1:0] status_w;
    logic [`FP_WORD_W-1:0] host_word;
    logic [`FP_ADDR_MSB:0] addr;
    logic start_fn;
    logic fail;
    logic den_fail;
    logic to_host;

    // ************
    // Next state
    // ************
    always_comb
    begin
        state_d = state_q;
        state_d.go = 1'b0;
        state_d.ac_load = 1'b0;
        state_d.skip = 1'b0;
        state_d.init = 1'b0;
        flag_set = 3'h0;
        flag_clr = 3'h0;
        start_fn = 1'b0;
        fail = 1'b0;
        den_fail = 1'b0;
        status_w = 12'h000;
        status_w[`FP_ST_CRC] = ctrl_crc_err_in;
        status_w[`FP_ST_INIT] = ctrl_init_done_in && (state_q.func != fn_status);
        status_w[`FP_ST_DUAL] = DUAL_DENSITY;
        status_w[`FP_ST_DEN_ERR] = ctrl_density_err_in;
        status_w[`FP_ST_UNIT_DEN] = DUAL_DENSITY && ctrl_unit_density_in[state_q.unit];
        status_w[`FP_ST_ERASED] = ctrl_erased_mark_in || (state_q.func == fn_write_del);
        status_w[`FP_ST_READY] = ctrl_unit_ready_in;
        host_word = state_q.wide8 ? {4'h0, host_main_reg_in[7:0]} : host_main_reg_in;
        addr = host_main_reg_in[`FP_ADDR_MSB:0];
        to_host = (state_q.step == st_idle) || (state_q.step == st_data_out) ||
                  (state_q.step == st_busy);
        if (io_strobe_in)
        begin
            unique case (io_op_in)
                op_nop:
                begin
                end
                command_load_op:
                begin
                    state_d.iface = host_main_reg_in;
                    state_d.ac_word = 12'h000;
                    state_d.ac_load = 1'b1;
                    state_d.maint = host_main_reg_in[`FP_MAINT_BIT];
                    if (!host_main_reg_in[`FP_MAINT_BIT])
                    begin
                        state_d.wide8 = host_main_reg_in[`FP_WIDE8_BIT];
                        state_d.func = func_t'(host_main_reg_in[`FP_FUNC_MSB:`FP_FUNC_LSB]);
                        state_d.unit = host_main_reg_in[`FP_UNIT_BIT];
                        if (DUAL_DENSITY && host_main_reg_in[`FP_WIDE8_BIT])
                        begin
                            state_d.step = st_cmd2;
                            flag_set[`FP_FLAG_TR] = 1'b1;
                        end
                        else
                        begin
                            state_d.dens = DUAL_DENSITY && host_main_reg_in[`FP_DENS_BIT];
                            start_fn = 1'b1;
                        end
                    end
                end
                data_move_op:
                begin
                    if (state_q.maint || to_host)
                    begin
                        state_d.ac_word = state_q.wide8 ?
                            {host_main_reg_in[11:8], host_main_reg_in[7:0] | state_q.iface[7:0]} :
                            state_q.iface;
                        state_d.ac_load = 1'b1;
                        state_d.go = !state_q.maint && (state_q.step == st_data_out);
                    end
                    else
                    begin
                        state_d.iface = host_word;
                        unique case (state_q.step)
                            st_cmd2:
                            begin
                                state_d.dens = host_main_reg_in[`FP_CMD2_DENS_BIT];
                                start_fn = 1'b1;
                            end
                            st_sector:
                            begin
                                if (addr >= 8'(`FP_SECTOR_FIRST) && addr <= 8'(SECTOR_LAST))
                                begin
                                    state_d.step = st_track;
                                    state_d.go = 1'b1;
                                end
                                else
                                begin
                                    fail = 1'b1;
                                end
                            end
                            st_track:
                            begin
                                if (addr <= 8'(TRACK_LAST))
                                begin
                                    state_d.step = st_busy;
                                    state_d.go = 1'b1;
                                end
                                else
                                begin
                                    fail = 1'b1;
                                end
                            end
                            st_data_in:
                            begin
                                state_d.go = 1'b1;
                            end
                            default:
                            begin
                            end
                        endcase
                    end
                end
                request_skip_op:
                begin
                    state_d.skip = flag_q[`FP_FLAG_TR];
                    flag_clr[`FP_FLAG_TR] = !state_q.maint;
                end
                error_skip_op:
                begin
                    state_d.skip = flag_q[`FP_FLAG_ERR];
                    flag_clr[`FP_FLAG_ERR] = !state_q.maint;
                end
                done_skip_op:
                begin
                    state_d.skip = flag_q[`FP_FLAG_DONE];
                    flag_clr[`FP_FLAG_DONE] = !state_q.maint;
                end
                irq_enable_op:
                begin
                    state_d.irq_en = host_main_reg_in[`FP_IE_BIT];
                end
                init_op:
                begin
                    state_d.maint = 1'b0;
                    state_d.irq_en = 1'b0;
                    state_d.wide8 = `FP_WIDE8_RST;
                    state_d.step = st_idle;
                    state_d.init = 1'b1;
                    flag_clr = 3'h7;
                end
            endcase
        end
        // Function start after full command
        if (start_fn)
        begin
            if (DUAL_DENSITY && (state_d.func inside {fn_write, fn_read, fn_write_del}) &&
                (state_d.dens != ctrl_unit_density_in[state_d.unit]))
            begin
                fail = 1'b1;
                den_fail = 1'b1;
            end
            else
            begin
                state_d.go = 1'b1;
                unique case (state_d.func)
                    fn_fill: state_d.step = st_data_in;
                    fn_empty: state_d.step = st_data_out;
                    fn_write, fn_read, fn_write_del: state_d.step = st_sector;
                    fn_density, fn_status, fn_fault: state_d.step = st_busy;
                endcase
            end
        end
        // Terminated function: status, error, done
        if (fail)
        begin
            state_d.iface = status_w;
            state_d.iface[`FP_ST_DEN_ERR] = status_w[`FP_ST_DEN_ERR] | den_fail;
            state_d.step = st_idle;
            flag_set[`FP_FLAG_ERR] = 1'b1;
            flag_set[`FP_FLAG_DONE] = 1'b1;
        end
        // Controller asks for or offers a word
        if (ctrl_request_in)
        begin
            flag_set[`FP_FLAG_TR] = 1'b1;
            if (state_q.step == st_data_out)
                state_d.iface = ctrl_word_in;
        end
        if (ctrl_done_in)
        begin
            flag_set[`FP_FLAG_DONE] = 1'b1;
            flag_set[`FP_FLAG_ERR] = ctrl_error_in;
            state_d.iface = (state_q.func == fn_fault) ? ctrl_word_in : status_w;
            state_d.step = st_idle;
        end
    end

    // State register
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= '{maint: 1'b0, irq_en: 1'b0, wide8: `FP_WIDE8_RST, func: fn_fill,
                         unit: 1'b0, dens: 1'b0, step: st_idle, iface: 12'h000,
                         ac_word: 12'h000, ac_load: 1'b0, skip: 1'b0, go: 1'b0, init: 1'b0};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ************
    // Skip flags
    // ************
    // maintenance forces flags
    for (genvar i = 0; i < 3; i++)
    begin : g_flag
        sticky_flag u_flag (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .set_in(flag_set[i]),
            .clear_in(flag_clr[i]),
            .force_in(state_q.maint),
            .flag_out(flag_q[i])
        );
    end

    // Outputs
    assign host_main_reg_out = state_q.ac_word;
    assign host_main_reg_load_out = state_q.ac_load;
    assign host_skip_out = state_q.skip;
    assign host_irq_out = flag_q[`FP_FLAG_DONE] & state_q.irq_en;
    assign word_request_flag_out = flag_q[`FP_FLAG_TR];
    assign error_flag_out = flag_q[`FP_FLAG_ERR];
    assign done_flag_out = flag_q[`FP_FLAG_DONE];
    assign ctrl_iface_out = state_q.iface;
    assign ctrl_go_out = state_q.go;
    assign ctrl_init_out = state_q.init;
    assign ctrl_func_out = state_q.func;
    assign ctrl_unit_out = state_q.unit;
    assign ctrl_dens_out = state_q.dens;
    assign ctrl_wide8_out = state_q.wide8;

    // ************
    // Checks
    // ************
    logic op_load;
    logic op_move;
    logic op_init;
    logic op_ie;
    assign op_load = io_strobe_in && (io_op_in == command_load_op);
    assign op_move = io_strobe_in && (io_op_in == data_move_op);
    assign op_init = io_strobe_in && (io_op_in == init_op);
    assign op_ie = io_strobe_in && (io_op_in == irq_enable_op);

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    AST_MAINT_SET: assert property (
        op_load && host_main_reg_in[`FP_MAINT_BIT] |=> ctrl_iface_out == $past(host_main_reg_in)
        && !ctrl_go_out) else $error("maintenance load misbehaved");
    AST_MAINT_NO_GO: assert property (
        state_q.maint && op_move |=> !ctrl_go_out && host_main_reg_load_out)
        else $error("go issued in maintenance");
    AST_MAINT_FLAGS: assert property (
        state_q.maint |=> word_request_flag_out && error_flag_out && done_flag_out)
        else $error("flags not held in maintenance");
    AST_MAINT_IRQ: assert property (
        state_q.maint && op_ie && host_main_reg_in[`FP_IE_BIT] && !op_init |=> host_irq_out)
        else $error("no interrupt in maintenance");
    AST_INIT_CLEARS: assert property (
        op_init && !state_q.maint && !ctrl_request_in && !ctrl_done_in |=>
        !word_request_flag_out && !error_flag_out && !done_flag_out && !host_irq_out
        && ctrl_init_out) else $error("initialize left state");
    AST_INIT_WIDTH: assert property (
        op_init |=> !ctrl_wide8_out [*1] ##0 !state_q.maint) else $error("not 12-bit after init");
    AST_IE_FOLLOWS: assert property (
        op_ie |=> state_q.irq_en == $past(host_main_reg_in[`FP_IE_BIT]))
        else $error("interrupt enable wrong");
    AST_STATUS_HIDES_INIT: assert property (
        ctrl_done_in && state_q.func == fn_status |=> !ctrl_iface_out[`FP_ST_INIT])
        else $error("init done shown in read status");
    AST_BYTE_READ: assert property (
        op_move && to_host && state_q.wide8 |=>
        host_main_reg_out[11:8] == $past(host_main_reg_in[11:8])) else $error("8-bit read jammed AC");

    COV_MAINT: cover property (op_load && host_main_reg_in[`FP_MAINT_BIT] ##1 op_move);
    COV_IRQ: cover property (host_irq_out);
    COV_CMD2: cover property (state_q.step == st_cmd2 ##[1:20] ctrl_go_out);

endmodule
`default_nettype wire

// ### testbench/host_proc_model.sv
/*
 Host processor model: issues one I/O instruction at a time, keeps the accumulator.
 Assumes: requests are spaced at least four cycles apart.
*/
`timescale 1ns/1ns
`default_nettype none
`include "floppy_port_regs.svh"

module host_proc_model
    import floppy_port_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire io_op_t op_in,
    input wire logic [`FP_WORD_W-1:0] ac_in,
    input wire logic [`FP_WORD_W-1:0] load_val_in,
    input wire logic load_in,
    input wire logic skip_in,
    output logic io_strobe_out,
    output var io_op_t io_op_out,
    output logic [`FP_WORD_W-1:0] ac_out,
    output logic res_valid_out,
    output logic res_skip_out,
    output logic [`FP_WORD_W-1:0] res_acc_out
);
    // ****************
    // Instruction issue
    // ****************
    logic wait_q;

    // Strobe one cycle, then take the answer the cycle after
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            io_strobe_out <= 1'b0;
            io_op_out <= op_nop;
            ac_out <= 12'h000;
            wait_q <= 1'b0;
            res_valid_out <= 1'b0;
            res_skip_out <= 1'b0;
            res_acc_out <= 12'h000;
        end
        else
        begin
            io_strobe_out <= req_in;
            if (req_in)
            begin
                io_op_out <= op_in;
                ac_out <= ac_in;
            end
            wait_q <= io_strobe_out;
            res_valid_out <= wait_q;
            if (wait_q)
            begin
                res_skip_out <= skip_in;
                res_acc_out <= load_in ? load_val_in : ac_out; // Jam only on load
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/test_floppy_interface_register_port.sv
/*
 Self-checking bench for the floppy interface register port.
 Assumes: host model in host_proc_model, controller events driven here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "floppy_port_regs.svh"

module test_floppy_interface_register_port
    import floppy_port_pkg::*;
;
    // ****************
    // Signals and parts
    // ****************
    logic clock_in = 1'b0, rst_in = 1'b1, req = 1'b0;
    io_op_t op = op_nop, hop;
    logic [11:0] ac = 12'h000, hac, rval, acc, ifc, v, cword = 12'h000;
    logic [1:0] udn = 2'b00;
    logic hstb, ld, skp, irq, trf, erf, dnf, rv, rs, go, ini, wd, un, dn;
    logic c_done = 1'b0, c_err = 1'b0, crc = 1'b0, initd = 1'b0, ers = 1'b0, rdy = 1'b0, creq = 1'b0;
    func_t fn;
    logic [12:0] q[$];
    logic [12:0] e;
    logic [3:0] st;
    int bad_count = 0, num_checks = 0, go_count = 0, ini_count = 0, cyc = 0, g0;

    always #10 clock_in = ~clock_in;

    host_proc_model host (.clock_in(clock_in), .rst_in(rst_in), .req_in(req), .op_in(op), .ac_in(ac),
        .load_val_in(rval), .load_in(ld), .skip_in(skp), .io_strobe_out(hstb), .io_op_out(hop),
        .ac_out(hac), .res_valid_out(rv), .res_skip_out(rs), .res_acc_out(acc));

    floppy_interface_register_port uut (.clock_in(clock_in), .rst_in(rst_in), .io_strobe_in(hstb),
        .io_op_in(hop), .host_main_reg_in(hac), .host_main_reg_out(rval), .host_main_reg_load_out(ld),
        .host_skip_out(skp), .host_irq_out(irq), .word_request_flag_out(trf), .error_flag_out(erf),
        .done_flag_out(dnf), .ctrl_request_in(creq), .ctrl_done_in(c_done), .ctrl_error_in(c_err),
        .ctrl_word_in(cword), .ctrl_crc_err_in(crc), .ctrl_init_done_in(initd),
        .ctrl_density_err_in(1'b0), .ctrl_unit_density_in(udn), .ctrl_erased_mark_in(ers),
        .ctrl_unit_ready_in(rdy), .ctrl_iface_out(ifc), .ctrl_go_out(go), .ctrl_init_out(ini),
        .ctrl_func_out(fn), .ctrl_unit_out(un), .ctrl_dens_out(dn), .ctrl_wide8_out(wd));

    // ****************
    // Tasks
    // ****************
    task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task end_sim();
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Issue one instruction, note the expected skip and accumulator
    task host_op(input io_op_t o, input logic [11:0] a, input logic s, input logic [11:0] x);
        q.push_back({s, x});
        @(posedge clock_in);
        req <= 1'b1;
        op <= o;
        ac <= a;
        @(posedge clock_in);
        req <= 1'b0;
        repeat (3) @(posedge clock_in);
    endtask

    task ctrl_fin(input logic er);
        @(posedge clock_in);
        c_done <= 1'b1;
        c_err <= er;
        @(posedge clock_in);
        c_done <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask

    // Answer compare, go counting and hang guard
    always @(posedge clock_in)
    begin
        if (rv && q.size() == 0)
            chk("answer", 12'h001, 12'h000);
        else if (rv)
        begin
            e = q.pop_front();
            chk("skip", 12'(rs), 12'(e[12]));
            chk("acc", acc, e[11:0]);
        end
        if (go === 1'b1)
            go_count++;
        if (ini === 1'b1)
            ini_count++;
        cyc++;
        if (cyc > 4000)
        begin
            bad_count++;
            end_sim();
        end
    end

    // ****************
    // Stimulus
    // ****************
    initial
    begin
        void'($urandom(32'ha5848840));
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk("wide8", 12'(wd), 12'h000);
        chk("flags", 12'({trf, erf, dnf, irq}), 12'h000);
        host_op(irq_enable_op, 12'h001, 1'b0, 12'h001);
        for (int f = 0; f < 8; f++)
        begin
            st = 4'($urandom);
            {crc, ers, rdy, initd} <= st;
            g0 = go_count;
            host_op(command_load_op, 12'(f * 2 + (f % 2) * 16), 1'b0, 12'h000);
            chk("func", 12'(fn), 12'(f));
            chk("unit", 12'(un), 12'(f % 2));
            chk("go", 12'(go_count - g0), 12'h001);
            ctrl_fin(f == 3);
            chk("done", 12'({erf, dnf, irq}), 12'({f == 3, 2'b11}));
            if (f != 7)
            begin
                chk("crc", 12'(ifc[`FP_ST_CRC]), 12'(st[3]));
                chk("erased", 12'(ifc[`FP_ST_ERASED]), 12'(st[2] | (f == 6)));
                chk("ready", 12'(ifc[`FP_ST_READY]), 12'(st[1]));
                chk("initdone", 12'(ifc[`FP_ST_INIT]), 12'(st[0] & (f != 5)));
            end
            if (f == 3)
                host_op(error_skip_op, 12'h000, 1'b1, 12'h000);
            host_op(done_skip_op, 12'h000, 1'b1, 12'h000);
        end
        // Empty buffer: controller offers a word, host reads it
        cword <= 12'($urandom);
        host_op(command_load_op, 12'h002, 1'b0, 12'h000);
        creq <= 1'b1;
        @(posedge clock_in);
        creq <= 1'b0;
        g0 = go_count;
        host_op(request_skip_op, 12'h000, 1'b1, 12'h000);
        host_op(data_move_op, 12'h000, 1'b0, cword);
        chk("go", 12'(go_count - g0), 12'h001);
        ctrl_fin(1'b0);
        host_op(done_skip_op, 12'h000, 1'b1, 12'h000);
        // Density mismatch on drive 1 ends the function
        udn <= 2'b10;
        g0 = go_count;
        host_op(command_load_op, 12'h014, 1'b0, 12'h000);
        chk("go", 12'(go_count - g0), 12'h000);
        chk("denerr", 12'({ifc[`FP_ST_DEN_ERR], erf, dnf}), 12'h007);
        host_op(error_skip_op, 12'h000, 1'b1, 12'h000);
        host_op(done_skip_op, 12'h000, 1'b1, 12'h000);
        // Sector 26 with upper nibble set, then track 77 refused
        udn <= 2'b01;
        g0 = go_count;
        host_op(command_load_op, 12'h104, 1'b0, 12'h000);
        host_op(data_move_op, 12'hf1a, 1'b0, 12'hf1a);
        host_op(data_move_op, 12'h04d, 1'b0, 12'h04d);
        chk("go", 12'(go_count - g0), 12'h002);
        chk("range", 12'({ifc[`FP_ST_UNIT_DEN], erf, dnf}), 12'h007);
        host_op(error_skip_op, 12'h000, 1'b1, 12'h000);
        host_op(done_skip_op, 12'h000, 1'b1, 12'h000);
        g0 = go_count;
        host_op(command_load_op, 12'h040, 1'b0, 12'h000);
        chk("wide8", 12'(wd), 12'h001);
        chk("go", 12'(go_count - g0), 12'h000);
        host_op(request_skip_op, 12'h000, 1'b1, 12'h000);
        host_op(data_move_op, 12'h001, 1'b0, 12'h001);
        chk("dens", 12'(dn), 12'h001);
        chk("go", 12'(go_count - g0), 12'h001);
        ctrl_fin(1'b0);
        host_op(done_skip_op, 12'h000, 1'b1, 12'h000);
        host_op(command_load_op, 12'h080, 1'b0, 12'h000);
        chk("flags", 12'({trf, erf, dnf, irq}), 12'h00f);
        host_op(irq_enable_op, 12'h000, 1'b0, 12'h000);
        chk("irq", 12'(irq), 12'h000);
        host_op(irq_enable_op, 12'h001, 1'b0, 12'h001);
        chk("irq", 12'(irq), 12'h001);
        v = (12'($urandom) & 12'hfbf) | 12'h080;
        g0 = go_count;
        host_op(command_load_op, v, 1'b0, 12'h000);
        host_op(data_move_op, 12'ha00, 1'b0, 12'ha00 | (v & 12'h0ff));
        chk("go", 12'(go_count - g0), 12'h000);
        host_op(done_skip_op, 12'h000, 1'b1, 12'h000);
        chk("flags", 12'({trf, erf, dnf}), 12'h007);
        host_op(command_load_op, 12'h000, 1'b0, 12'h000);
        host_op(error_skip_op, 12'h000, 1'b1, 12'h000);
        host_op(init_op, 12'h000, 1'b0, 12'h000);
        chk("flags", 12'({trf, erf, dnf, irq, wd}), 12'h000);
        chk("init", 12'(ini_count), 12'h001);
        end_sim();
    end
endmodule
`default_nettype wire
